// ### hdl/pmt_pkg.sv
// shared constants for the program memory table-read path
package pmt_pkg;
    localparam int PMT_ADDR_W = 10;
    localparam int PMT_WORD_W = 14;
    localparam int PMT_BYTE_W = 8;
    localparam int PMT_DEPTH = 1024;
    localparam logic [9:0] PMT_RESET_VECTOR = 10'h000;
    localparam logic [1:0] PMT_LAST_PAGE = 2'h3;
    localparam logic [7:0] PMT_HIGH_RESET = 8'h00;
    localparam int PMT_TABLE_CYCLES = 2;
    typedef enum logic [1:0] {
        PMT_OP_NONE,
        PMT_OP_CURRENT,
        PMT_OP_LAST
    } pmt_op_t;
    typedef enum {
        PMT_IDLE,
        PMT_READ
    } pmt_state_t;
endpackage

// ### hdl/pmt_prog_port.sv
`timescale 1ns/1ns
// serial programming port: shifts words in and out of the program store
module pmt_prog_port
    import pmt_pkg::*;
#(
    parameter int ADDR_W = PMT_ADDR_W,
    parameter int WORD_W = PMT_WORD_W
) (
    // system
    input wire logic clk_sys,
    input wire logic nrst,
    // programming pins
    input wire logic progSerialClock,
    input wire logic progSerialDataIn,
    output logic progSerialDataOut,
    output logic progSerialDataOe,
    input wire logic progEnable,
    // store access
    output logic [ADDR_W-1:0] pgmAddr,
    output logic [WORD_W-1:0] pgmWrData,
    output logic pgmWrite,
    input wire logic [WORD_W-1:0] pgmRdData
);
    localparam int FRAME_W = 2 + ADDR_W + WORD_W;
    localparam int CNT_W = $clog2(FRAME_W + 1);
    initial begin
        if (WORD_W < 1 || ADDR_W < 1) $error("bad widths");
    end
    logic [2:0] clkSync_reg;
    logic dataMeta_reg;
    logic data_reg;
    logic [FRAME_W-1:0] shift_reg;
    logic [CNT_W-1:0] count_reg;
    logic [WORD_W-1:0] readBack_reg;
    logic readMode_reg;
    logic sclkRise;
    // two flops before use; the third stage only feeds edge detection
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clkSync_reg <= 3'h0;
            dataMeta_reg <= 1'b0;
            data_reg <= 1'b0;
        end else begin
            clkSync_reg <= {clkSync_reg[1:0], progSerialClock};
            dataMeta_reg <= progSerialDataIn;
            data_reg <= dataMeta_reg;
        end
    end
    assign sclkRise = clkSync_reg[1] & ~clkSync_reg[2];
    // frame: read flag, write flag, address, word, msb first
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= '0;
            count_reg <= '0;
            pgmWrite <= 1'b0;
            pgmAddr <= '0;
            pgmWrData <= '0;
            readMode_reg <= 1'b0;
            readBack_reg <= '0;
        end else begin
            pgmWrite <= 1'b0;
            if (!progEnable) begin
                count_reg <= '0;
                readMode_reg <= 1'b0;
            end else if (sclkRise) begin
                shift_reg <= {shift_reg[FRAME_W-2:0], data_reg};
                if (readMode_reg) begin
                    readBack_reg <= {readBack_reg[WORD_W-2:0], 1'b0};
                end
                if (count_reg == CNT_W'(1 + ADDR_W)
                    && shift_reg[ADDR_W]) begin
                    // read frame: address known, load word to shift out
                    pgmAddr <= {shift_reg[ADDR_W-2:0], data_reg};
                    readMode_reg <= 1'b1;
                end
                if (count_reg == CNT_W'(FRAME_W - 1)) begin
                    count_reg <= '0;
                    readMode_reg <= 1'b0;
                    if (shift_reg[FRAME_W-3]) begin
                        pgmAddr <= shift_reg[WORD_W+ADDR_W-2:WORD_W-1];
                        pgmWrData <= {shift_reg[WORD_W-2:0], data_reg};
                        pgmWrite <= 1'b1;
                    end
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end else if (readMode_reg
                && count_reg == CNT_W'(2 + ADDR_W)) begin
                // preload between edges: msb must stand before clock 13
                readBack_reg <= pgmRdData;
            end
        end
    end
    // data line driven only while a read word is shifted out
    assign progSerialDataOut = readBack_reg[WORD_W-1];
    assign progSerialDataOe = readMode_reg
        && count_reg >= CNT_W'(2 + ADDR_W);
endmodule

// ### hdl/pmt_table_read.sv
`timescale 1ns/1ns
// program store, fetch path and table-read unit
module pmt_table_read
    import pmt_pkg::*;
#(
    parameter int ADDR_W = PMT_ADDR_W,
    parameter int WORD_W = PMT_WORD_W,
    parameter int DEPTH = PMT_DEPTH
) (
    // system
    input wire logic clk_sys,
    input wire logic nrst,
    // program counter from the core
    input wire logic pcLoad,
    input wire logic [ADDR_W-1:0] pcLoadValue,
    input wire logic pcAdvance,
    output logic [ADDR_W-1:0] programCounter,
    output logic [WORD_W-1:0] fetchWord,
    // table read request
    input wire pmt_pkg::pmt_op_t tableOp,
    input wire logic [PMT_BYTE_W-1:0] tablePointer,
    input wire logic [PMT_BYTE_W-1:0] operandAddr,
    output logic tableBusy,
    // results
    output logic dataWrite,
    output logic [PMT_BYTE_W-1:0] dataWriteAddr,
    output logic [PMT_BYTE_W-1:0] dataWriteValue,
    output logic [PMT_BYTE_W-1:0] tableHighByte,
    // programming pins
    input wire logic progEnable,
    input wire logic progSerialClock,
    input wire logic progSerialDataIn,
    output logic progSerialDataOut,
    output logic progSerialDataOe
);
    import pmt_pkg::*;
    localparam int HIGH_W = WORD_W - PMT_BYTE_W;
    initial begin
        if (ADDR_W <= PMT_BYTE_W || DEPTH != (1 << ADDR_W)
            || HIGH_W < 1 || HIGH_W > PMT_BYTE_W) begin
            $error("unsupported store geometry");
        end
    end
    logic [WORD_W-1:0] store [DEPTH];
    logic [ADDR_W-1:0] pc_reg;
    logic [ADDR_W-1:0] pc_next;
    pmt_state_t state_reg;
    logic [ADDR_W-1:0] tableAddr_reg;
    logic [PMT_BYTE_W-1:0] operand_reg;
    logic [PMT_BYTE_W-1:0] high_reg;
    logic [PMT_BYTE_W-1:0] low_reg;
    logic [PMT_BYTE_W-1:0] wrAddr_reg;
    logic wr_reg;
    logic [ADDR_W-1:0] tableAddr;
    logic [ADDR_W-1:0] progAddr;
    logic [WORD_W-1:0] progWrData;
    logic progWrite;
    logic [WORD_W-1:0] tableWord;
    // table address: page bits from pc or last page, low byte from pointer
    always_comb begin
        if (tableOp == PMT_OP_LAST) begin
            tableAddr = {PMT_LAST_PAGE, tablePointer};
        end else begin
            tableAddr = {pc_reg[ADDR_W-1:PMT_BYTE_W], tablePointer};
        end
    end
    // pc does not advance during table reads so the core sees the stall; pcLoad still loads it
    always_comb begin
        pc_next = pc_reg;
        if (pcLoad) begin
            pc_next = pcLoadValue;
        end else if (pcAdvance && state_reg == PMT_IDLE) begin
            pc_next = pc_reg + 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pc_reg <= PMT_RESET_VECTOR;
        end else begin
            pc_reg <= pc_next;
        end
    end
    // store: programming writes, fetch and table read ports
    always_ff @(posedge clk_sys) begin
        if (progWrite) begin
            store[progAddr] <= progWrData;
        end
    end
    assign fetchWord = store[pc_reg];
    assign tableWord = store[tableAddr_reg];
    // two-state sequencer: capture address, then read and deliver
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= PMT_IDLE;
            tableAddr_reg <= '0;
            operand_reg <= '0;
        end else begin
            unique case (state_reg)
                PMT_IDLE: begin
                    if (tableOp != PMT_OP_NONE && !progEnable) begin
                        tableAddr_reg <= tableAddr;
                        operand_reg <= operandAddr;
                        state_reg <= PMT_READ;
                    end
                end
                PMT_READ: begin
                    state_reg <= PMT_IDLE;
                end
            endcase
        end
    end
    // results land at the end of the second cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            high_reg <= PMT_HIGH_RESET;
            low_reg <= '0;
            wrAddr_reg <= '0;
            wr_reg <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (state_reg == PMT_READ) begin
                low_reg <= tableWord[PMT_BYTE_W-1:0];
                wrAddr_reg <= operand_reg;
                wr_reg <= 1'b1;
                // no write path exists: only a table read or reset changes it
                high_reg <= PMT_BYTE_W'(tableWord[WORD_W-1:PMT_BYTE_W]);
            end
        end
    end
    // main/isr sharing of the holding register is left to software
    assign tableBusy = state_reg == PMT_READ;
    assign programCounter = pc_reg;
    assign dataWrite = wr_reg;
    assign dataWriteAddr = wrAddr_reg;
    assign dataWriteValue = low_reg;
    assign tableHighByte = high_reg;
    pmt_prog_port #(
        .ADDR_W(ADDR_W),
        .WORD_W(WORD_W)
    ) progPort (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .progSerialClock(progSerialClock),
        .progSerialDataIn(progSerialDataIn),
        .progSerialDataOut(progSerialDataOut),
        .progSerialDataOe(progSerialDataOe),
        .progEnable(progEnable),
        .pgmAddr(progAddr),
        .pgmWrData(progWrData),
        .pgmWrite(progWrite),
        .pgmRdData(store[progAddr])
    );
endmodule

// ### tb/pmt_table_read_asserts.sv
`timescale 1ns/1ns
// port assertions for the table-read path
module pmt_table_read_asserts
    import pmt_pkg::*;
#(
    parameter int ADDR_W = PMT_ADDR_W
) (
    // system
    input wire logic clk_sys,
    input wire logic nrst,
    // core side
    input wire logic pcLoad,
    input wire logic [ADDR_W-1:0] pcLoadValue,
    input wire logic pcAdvance,
    input wire logic [ADDR_W-1:0] programCounter,
    input wire pmt_pkg::pmt_op_t tableOp,
    input wire logic [PMT_BYTE_W-1:0] operandAddr,
    input wire logic tableBusy,
    input wire logic progEnable,
    // results
    input wire logic dataWrite,
    input wire logic [PMT_BYTE_W-1:0] dataWriteAddr,
    input wire logic [PMT_BYTE_W-1:0] tableHighByte
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // a request the device accepts
    sequence sTaken;
        tableOp != PMT_OP_NONE && !progEnable && !tableBusy;
    endsequence
    // one busy cycle, then the write pulse
    sequence sAnswer;
        tableBusy ##1 (dataWrite && !tableBusy);
    endsequence
    a_take_then_answer: assert property (sTaken |=> sAnswer)
        else $error("table read answer not two cycles after request");
    a_write_after_busy: assert property (dataWrite |-> $past(tableBusy))
        else $error("write pulse without a busy cycle");
    a_write_dest: assert property (dataWrite |-> dataWriteAddr == $past(operandAddr, 2))
        else $error("write address is not the operand");
    a_high_top_zero: assert property (tableHighByte[7:6] == 2'h0)
        else $error("unused high bits not zero");
    a_high_held: assert property (!dataWrite |-> $stable(tableHighByte))
        else $error("high byte changed outside a table read");
    a_prog_refuse: assert property (progEnable |=> !tableBusy)
        else $error("table read taken during programming");
    a_pc_load: assert property (pcLoad |=> programCounter == $past(pcLoadValue))
        else $error("pc not loaded");
    a_pc_advance: assert property (pcAdvance && !pcLoad && !tableBusy |=> programCounter == $past(programCounter) + 1'b1)
        else $error("pc not advanced");
    a_pc_stall: assert property (tableBusy && !pcLoad |=> $stable(programCounter))
        else $error("pc moved in busy cycle");
endmodule
bind pmt_table_read pmt_table_read_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .pcAdvance(pcAdvance), .programCounter(programCounter), .tableOp(tableOp),
    .operandAddr(operandAddr), .tableBusy(tableBusy), .progEnable(progEnable),
    .dataWrite(dataWrite), .dataWriteAddr(dataWriteAddr),
    .tableHighByte(tableHighByte)
);

// ### tb/pmt_programmer.sv
`timescale 1ns/1ns
// external programmer model on the serial programming pins
module pmt_programmer (
    // from the device
    input wire logic dataOut,
    input wire logic dataOe,
    // to the device
    output logic serialClock,
    output wire logic serialData,
    output logic oeSeen,
    output logic [13:0] readWord
);
    logic drvOe = 1'h0;
    logic drvVal = 1'h0;
    // one data line: device wins while driving, pull-up when nobody does
    assign serialData = dataOe ? dataOut : (drvOe ? drvVal : 1'h1);
    initial serialClock = 1'h0;
    initial oeSeen = 1'h0;
    initial readWord = 14'h0000;
    // one frame msb first; clock idles low between frames
    task automatic send_frame(input logic rd, input logic [9:0] addr,
            input logic [13:0] data);
        logic [25:0] bits;
        bits = {rd, ~rd, addr, data};
        for (int i = 25; i >= 0; i--) begin
            drvOe = !(rd && i < 14);
            drvVal = bits[i];
            #500;
            serialClock = 1'h1;
            if (dataOe)
                oeSeen = 1'h1;
            // collect the word the device shifts back, msb first
            if (rd && i < 14)
                readWord[i] = serialData;
            #500;
            serialClock = 1'h0;
        end
        drvOe = 1'h0;
        #1000;
    endtask
endmodule

// ### tb/pmt_table_read_tb.sv
`timescale 1ns/1ns
// self-checking bench for the table-read path
module pmt_table_read_tb;
    import pmt_pkg::*;
    typedef struct {pmt_op_t op; logic [9:0] pc; logic [7:0] ptr;
        logic [7:0] dst; logic [9:0] addr; logic [13:0] word;} pmt_row_t;
    // rows: op, pc, pointer, operand, word address, stored word
    pmt_row_t rows [4] = '{
        '{PMT_OP_LAST, 10'h1C0, 8'h06, 8'h40, 10'h306, 14'h3F1A},
        '{PMT_OP_LAST, 10'h1C0, 8'h05, 8'h41, 10'h305, 14'h000F},
        '{PMT_OP_CURRENT, 10'h1C0, 8'h05, 8'h42, 10'h105, 14'h2A55},
        '{PMT_OP_CURRENT, 10'h000, 8'hF0, 8'h43, 10'h0F0, 14'h1234}};
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic pcLoad = 1'h0;
    logic pcAdvance = 1'h0;
    logic progEnable = 1'h1;
    logic [9:0] pcLoadValue = 10'h000;
    pmt_op_t tableOp = PMT_OP_NONE;
    logic [7:0] tablePointer = 8'h00;
    logic [7:0] operandAddr = 8'h00;
    logic [9:0] programCounter;
    logic [13:0] fetchWord;
    logic tableBusy, dataWrite, sclk, sdata, sdo, sdoe, oeSeen;
    logic [7:0] dataWriteAddr, dataWriteValue, tableHighByte;
    logic [13:0] readWord;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    pmt_table_read u_dut (.clk_sys(clk_sys), .nrst(nrst), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .pcAdvance(pcAdvance),
        .programCounter(programCounter), .fetchWord(fetchWord),
        .tableOp(tableOp), .tablePointer(tablePointer),
        .operandAddr(operandAddr), .tableBusy(tableBusy),
        .dataWrite(dataWrite), .dataWriteAddr(dataWriteAddr),
        .dataWriteValue(dataWriteValue), .tableHighByte(tableHighByte),
        .progEnable(progEnable), .progSerialClock(sclk),
        .progSerialDataIn(sdata), .progSerialDataOut(sdo),
        .progSerialDataOe(sdoe));
    pmt_programmer u_prog (.dataOut(sdo), .dataOe(sdoe), .serialClock(sclk),
        .serialData(sdata), .oeSeen(oeSeen), .readWord(readWord));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // whole run is about 1700 cycles; a hang is stopped at cycle 5000
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // pc set for the page, one read, result seen the cycle after busy
    // reads never overlap, as with interrupts masked in the main routine
    task automatic table_read(input pmt_row_t r);
        pcLoad = 1'h1;
        pcLoadValue = r.pc;
        @(negedge clk_sys);
        pcLoad = 1'h0;
        tableOp = r.op;
        tablePointer = r.ptr;
        operandAddr = r.dst;
        @(negedge clk_sys);
        tableOp = PMT_OP_NONE;
        check(tableBusy, 1'h1);
        @(negedge clk_sys);
        check(dataWrite, 1'h1);
        check(dataWriteAddr, r.dst);
        check(dataWriteValue, r.word[7:0]);
        check(tableHighByte, {2'h0, r.word[13:8]});
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        nrst = 1'h1;
        @(negedge clk_sys);
        check(programCounter, 10'h000);
        foreach (rows[i])
            u_prog.send_frame(1'h0, rows[i].addr, rows[i].word);
        u_prog.send_frame(1'h0, 10'h000, 14'h0ABC);
        u_prog.send_frame(1'h1, 10'h306, 14'h0000);
        check(oeSeen, 1'h1);
        check(readWord, 14'h3F1A);
        check(fetchWord, 14'h0ABC);
        $display("programming done");
        progEnable = 1'h0;
        @(negedge clk_sys);
        foreach (rows[i])
            table_read(rows[i]);
        $display("table rows done");
        // request held: second one is taken in the answer cycle
        tableOp = PMT_OP_LAST;
        tablePointer = 8'h06;
        repeat (2) @(negedge clk_sys);
        tablePointer = 8'h05;
        check(tableHighByte, 8'h3F);
        repeat (2) @(negedge clk_sys);
        tableOp = PMT_OP_NONE;
        check(dataWrite, 1'h1);
        check(dataWriteValue, 8'h0F);
        $display("back-to-back done");
        // refused while programming: nothing may change
        progEnable = 1'h1;
        tableOp = PMT_OP_LAST;
        tablePointer = 8'h06;
        repeat (3) @(negedge clk_sys);
        check(dataWrite, 1'h0);
        check(tableHighByte, 8'h00);
        tableOp = PMT_OP_NONE;
        progEnable = 1'h0;
        $display("refusal done");
        // reset in mid-run clears pc and holding byte
        table_read(rows[0]);
        nrst = 1'h0;
        @(negedge clk_sys);
        check(programCounter, 10'h000);
        check(tableHighByte, 8'h00);
        nrst = 1'h1;
        pcAdvance = 1'h1;
        repeat (3) @(negedge clk_sys);
        pcAdvance = 1'h0;
        check(programCounter, 10'h003);
        $display("reset and fetch done");
        tally_and_finish();
    end
endmodule
